/* File: pkg/tsw_pkg.sv */
/*
 * tsw_pkg: register map, field layout, reset values, timing and display
 * glyph constants for the threshold switching output.
 * Assumes a single 20 MHz system clock.
 */
package tsw_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THR_LO = 8'h04;
    localparam logic [7:0] OFS_THR_HI = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0c;
    localparam logic [7:0] OFS_SIM_VAL = 8'h10;
    localparam logic [7:0] OFS_KFIT = 8'h14;
    localparam logic [7:0] OFS_KSENS = 8'h18;
    localparam logic [7:0] OFS_K_EFF = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_PV = 8'h24;
    localparam logic [7:0] OFS_KEY_VAL = 8'h28;

    // control field positions
    localparam int CTRL_WINDOW_BIT = 0;
    localparam int CTRL_INVERT_BIT = 1;
    localparam int CTRL_DLY_EN_BIT = 2;
    localparam int CTRL_SIM_EN_BIT = 3;
    localparam int CTRL_STAGE_LSB = 4;
    localparam int CTRL_KCLR_BIT = 8;

    // reset values
    localparam logic [15:0] RST_THR_LO = 16'h0000;
    localparam logic [15:0] RST_THR_HI = 16'hffff;
    localparam logic [15:0] RST_K = 16'h0100;
    localparam logic [3:0] RST_STAGE = 4'h0;
    localparam logic [3:0] STAGE_MAX = 4'h9;

    // delay tick: 1 ms at 20 MHz
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = (CLK_HZ / 1000) * (TICK_NS / 1_000_000) / 1000 * 1000;

    // fixed point: factors are 8.8
    localparam int K_FRAC = 8;
    localparam int NUM_CHARS = 8;
    localparam int NUM_SEGS = 15;

    typedef enum logic [1:0] {
        LVL_DISP = 2'b00,
        LVL_PROG = 2'b01,
        LVL_ADJ = 2'b10
    } tsw_level_t;

    typedef struct packed {
        logic window;
        logic invert;
        logic dly_en;
        logic sim_en;
        logic [3:0] stage;
    } tsw_cfg_t;

    typedef struct packed {
        logic up;
        logic next;
        logic ok;
    } tsw_keys_t;

    // 15-segment glyphs for hex digits 0..f
    localparam logic [14:0] GLYPH [16] = '{
        15'h003f, 15'h0006, 15'h00db, 15'h008f, 15'h00e6, 15'h00ed, 15'h00fd, 15'h0007,
        15'h00ff, 15'h00ef, 15'h00f7, 15'h128f, 15'h0039, 15'h120f, 15'h00f9, 15'h0071
    };
endpackage

/* File: rtl/tsw_top.sv */
/*
 * tsw_top: threshold switching output with delay, input filter, scaling,
 * simulation substitute, keypad levels and 8-character display driver.
 * Assumes all inputs synchronous to clk_sys and a register master that
 * never issues read and write strobes together.
 */
// The register offsets and the address-and-strobe port were decided locally.
// How it works
// - hysteresis normal: rising value switches on only at high threshold
// - hysteresis normal: falling value switches off at low threshold
// - hysteresis inverted: rising value switches off at high threshold
// - hysteresis inverted: falling value switches on at low threshold
// - window normal rising: on at low, off at high
// - window normal falling: on at high, off at low
// - window inverted rising: off at low, on at high
// - window inverted falling: off at high, on at low
// - with delay, output holds until delay expires and condition persists
// - value back in range before expiry: output unchanged
// - window/hysteresis, normal/inverted, delay on/off: eight modes
// - filter stage 0 none up to 9 strongest
// - conversion factor is fitting factor times sensor factor
// - successful teach-in replaces factor and shows it on display
// - simulation mode evaluates thresholds against entered value
// - display drives eight characters of fifteen segments
// - three keys: adjust digit value, next digit, confirm
// - three levels: display, program, adjust and test with sensor frequency
`timescale 1ns/100ps
module tsw_top
    import tsw_pkg::*;
#(
    parameter int DLY_TICK_CYC = TICK_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // measurement
    input wire logic [15:0] meas_raw,
    input wire logic meas_vld,
    input wire logic [15:0] sens_freq,
    // teach-in result
    input wire logic cal_ok,
    input wire logic [15:0] cal_k,
    // keypad
    input wire tsw_keys_t keys,
    // outputs
    output logic sw_out,
    output logic [1:0] level,
    output logic [NUM_CHARS*NUM_SEGS-1:0] disp_seg
);

    tsw_cfg_t cfg_r;
    logic [15:0] thr_lo_r;
    logic [15:0] thr_hi_r;
    logic [15:0] delay_r;
    logic [15:0] sim_val_r;
    logic [15:0] kfit_r;
    logic [15:0] ksens_r;
    logic [15:0] kcal_r;
    logic kcal_vld_r;
    logic show_k_r;
    logic [31:0] k_prod;
    logic [15:0] k_eff;
    logic [31:0] scaled;
    logic [15:0] pv_meas;
    logic [23:0] filt_r;
    logic [24:0] filt_diff;
    logic [3:0] stage_eff;
    logic [15:0] pv_filt;
    logic [15:0] pv;
    logic want_on;
    logic sw_r;
    logic [15:0] dly_cnt_r;
    logic [31:0] tick_cnt_r;
    logic tick;
    tsw_level_t lvl_r;
    tsw_keys_t keys_prev_r;
    tsw_keys_t key_hit;
    logic [15:0] edit_r;
    logic [1:0] digit_r;
    logic [15:0] key_val_r;
    logic [31:0] disp_val;
    logic [NUM_CHARS*NUM_SEGS-1:0] seg_nxt;
    logic [NUM_CHARS*NUM_SEGS-1:0] seg_r;
    logic [31:0] rdata_r;
    logic wr_hit;

    // register writes
    assign wr_hit = reg_wr;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r <= '0;
            thr_lo_r <= RST_THR_LO;
            thr_hi_r <= RST_THR_HI;
            delay_r <= 16'h0000;
            sim_val_r <= 16'h0000;
            kfit_r <= RST_K;
            ksens_r <= RST_K;
        end
        else if (wr_hit)
        begin
            unique case (reg_addr)
                OFS_CTRL:
                begin
                    cfg_r.window <= reg_wdata[CTRL_WINDOW_BIT];
                    cfg_r.invert <= reg_wdata[CTRL_INVERT_BIT];
                    cfg_r.dly_en <= reg_wdata[CTRL_DLY_EN_BIT];
                    cfg_r.sim_en <= reg_wdata[CTRL_SIM_EN_BIT];
                    cfg_r.stage <= reg_wdata[CTRL_STAGE_LSB +: 4];
                end
                OFS_THR_LO: thr_lo_r <= reg_wdata[15:0];
                OFS_THR_HI: thr_hi_r <= reg_wdata[15:0];
                OFS_DELAY: delay_r <= reg_wdata[15:0];
                OFS_SIM_VAL: sim_val_r <= reg_wdata[15:0];
                OFS_KFIT: kfit_r <= reg_wdata[15:0];
                OFS_KSENS: ksens_r <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // teach-in factor; a new result wins over a software clear
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kcal_r <= RST_K;
            kcal_vld_r <= 1'b0;
        end
        else if (cal_ok)
        begin
            kcal_r <= cal_k;
            kcal_vld_r <= 1'b1;
        end
        else if (wr_hit && reg_addr == OFS_CTRL && reg_wdata[CTRL_KCLR_BIT])
        begin
            kcal_vld_r <= 1'b0;
        end
    end

    // scaling
    assign k_prod = kfit_r * ksens_r;
    assign k_eff = kcal_vld_r ? kcal_r : k_prod[K_FRAC +: 16];
    assign scaled = meas_raw * k_eff;
    assign pv_meas = (|scaled[31:24]) ? 16'hffff : scaled[K_FRAC +: 16];

    // first-order smoothing, coefficient 2^-stage
    assign stage_eff = (cfg_r.stage > STAGE_MAX) ? STAGE_MAX : cfg_r.stage;
    assign filt_diff = $signed({1'b0, pv_meas, 8'h00}) - $signed({1'b0, filt_r});

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_r <= 24'h000000;
        end
        else if (meas_vld)
        begin
            filt_r <= filt_r + 24'($signed(filt_diff) >>> stage_eff);
        end
    end

    assign pv_filt = filt_r[23:8];
    assign pv = cfg_r.sim_en ? sim_val_r : pv_filt;

    // target output state for the selected mode
    always_comb
    begin
        want_on = sw_r;
        if (cfg_r.window)
        begin
            // inside the window is on, outside off; polarity swaps it
            want_on = ((pv >= thr_lo_r) && (pv < thr_hi_r)) ^ cfg_r.invert;
        end
        else if (pv >= thr_hi_r)
        begin
            want_on = !cfg_r.invert;
        end
        else if (pv <= thr_lo_r)
        begin
            want_on = cfg_r.invert;
        end
    end

    // delay tick prescaler
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_r <= 32'h00000000;
        end
        else if (tick)
        begin
            tick_cnt_r <= 32'h00000000;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end

    assign tick = (tick_cnt_r >= 32'(DLY_TICK_CYC - 1));

    // switching output with optional delay
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_r <= 1'b0;
            dly_cnt_r <= 16'h0000;
        end
        else if (want_on == sw_r)
        begin
            dly_cnt_r <= 16'h0000;
        end
        else if (!cfg_r.dly_en || dly_cnt_r >= delay_r)
        begin
            sw_r <= want_on;
            dly_cnt_r <= 16'h0000;
        end
        else if (tick)
        begin
            dly_cnt_r <= dly_cnt_r + 16'h0001;
        end
    end

    // keypad edges
    assign key_hit = keys & ~keys_prev_r;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            keys_prev_r <= '0;
        end
        else
        begin
            keys_prev_r <= keys;
        end
    end

    // operating levels and value entry
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_r <= LVL_DISP;
            edit_r <= 16'h0000;
            digit_r <= 2'h0;
            key_val_r <= 16'h0000;
        end
        else
        begin
            unique case (lvl_r)
                LVL_DISP:
                begin
                    if (key_hit.ok)
                    begin
                        lvl_r <= LVL_PROG;
                    end
                end
                LVL_PROG:
                begin
                    if (key_hit.ok)
                    begin
                        key_val_r <= edit_r;
                        lvl_r <= LVL_ADJ;
                    end
                    else if (key_hit.next)
                    begin
                        digit_r <= digit_r + 2'h1;
                    end
                    else if (key_hit.up)
                    begin
                        edit_r[digit_r*4 +: 4] <= edit_r[digit_r*4 +: 4] + 4'h1;
                    end
                end
                LVL_ADJ:
                begin
                    if (key_hit.ok)
                    begin
                        lvl_r <= LVL_DISP;
                    end
                end
                default: lvl_r <= LVL_DISP;
            endcase
        end
    end

    // display holds the new factor until a key is pressed
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            show_k_r <= 1'b0;
        end
        else if (cal_ok)
        begin
            show_k_r <= 1'b1;
        end
        else if (|key_hit)
        begin
            show_k_r <= 1'b0;
        end
    end

    // display content per level
    always_comb
    begin
        disp_val = {16'h0000, pv};
        if (show_k_r)
        begin
            disp_val = {16'h0000, k_eff};
        end
        else if (lvl_r == LVL_PROG)
        begin
            disp_val = {14'h0000, digit_r, edit_r};
        end
        else if (lvl_r == LVL_ADJ)
        begin
            disp_val = {16'h0000, sens_freq};
        end
    end

    always_comb
    begin
        seg_nxt = '0;
        for (int i = 0; i < NUM_CHARS; i++)
        begin
            seg_nxt[i*NUM_SEGS +: NUM_SEGS] = GLYPH[disp_val[i*4 +: 4]];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_r <= '0;
        end
        else
        begin
            seg_r <= seg_nxt;
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= 32'h00000000;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_CTRL: rdata_r <= {24'h000000, cfg_r.stage, cfg_r.sim_en, cfg_r.dly_en,
                                      cfg_r.invert, cfg_r.window};
                OFS_THR_LO: rdata_r <= {16'h0000, thr_lo_r};
                OFS_THR_HI: rdata_r <= {16'h0000, thr_hi_r};
                OFS_DELAY: rdata_r <= {16'h0000, delay_r};
                OFS_SIM_VAL: rdata_r <= {16'h0000, sim_val_r};
                OFS_KFIT: rdata_r <= {16'h0000, kfit_r};
                OFS_KSENS: rdata_r <= {16'h0000, ksens_r};
                OFS_K_EFF: rdata_r <= {16'h0000, k_eff};
                OFS_STATUS: rdata_r <= {16'h0000, dly_cnt_r[11:0], kcal_vld_r,
                                        lvl_r, sw_r};
                OFS_PV: rdata_r <= {16'h0000, pv};
                OFS_KEY_VAL: rdata_r <= {16'h0000, key_val_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
        else
        begin
            rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_r;
    assign sw_out = sw_r;
    assign level = lvl_r;
    assign disp_seg = seg_r;

endmodule

/* File: tb/tsw_top_assertions.sv */
/* tsw_top_assertions: port-level checks of the switching output and register port.
 * Assumes it is bound to tsw_top and sees only its ports. */
`timescale 1ns/100ps
module tsw_top_assertions
    import tsw_pkg::*;
#(
    parameter int DLY_TICK_CYC = TICK_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // outputs
    input wire logic sw_out,
    input wire logic [1:0] level
);
    logic [3:0] cfg_r;
    logic [15:0] lo_r;
    logic [15:0] hi_r;
    logic [15:0] sv_r;
    logic [1:0] q_r;
    logic set_w;
    logic in_w;

    // shadow of the settings written by software
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r <= 4'h0;
            lo_r <= RST_THR_LO;
            hi_r <= RST_THR_HI;
            sv_r <= 16'h0000;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_CTRL)
                cfg_r <= reg_wdata[3:0];
            if (reg_addr == OFS_THR_LO)
                lo_r <= reg_wdata[15:0];
            if (reg_addr == OFS_THR_HI)
                hi_r <= reg_wdata[15:0];
            if (reg_addr == OFS_SIM_VAL)
                sv_r <= reg_wdata[15:0];
        end
    end

    // cycles since the last write, saturating
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= 2'h0;
        else if (reg_wr)
            q_r <= 2'h0;
        else if (q_r != 2'h3)
            q_r <= q_r + 2'h1;
    end

    assign set_w = q_r == 2'h3 && cfg_r[3] && !cfg_r[2] && lo_r < hi_r;
    assign in_w = sv_r >= lo_r && sv_r < hi_r;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    hys_rise_on_a: assert property (set_w && !cfg_r[0] && !cfg_r[1]
        && sv_r >= hi_r |-> sw_out)
        else $error("output not on at high threshold");
    hys_fall_off_a: assert property (set_w && !cfg_r[0] && !cfg_r[1]
        && sv_r <= lo_r |-> !sw_out)
        else $error("output not off at low threshold");
    inv_rise_off_a: assert property (set_w && !cfg_r[0] && cfg_r[1]
        && sv_r >= hi_r |-> !sw_out)
        else $error("inverted output not off at high threshold");
    inv_fall_on_a: assert property (set_w && !cfg_r[0] && cfg_r[1]
        && sv_r <= lo_r |-> sw_out)
        else $error("inverted output not on at low threshold");
    hys_hold_a: assert property (set_w && !cfg_r[0] && sv_r > lo_r
        && sv_r < hi_r |=> $stable(sw_out))
        else $error("output moved between thresholds");
    win_norm_a: assert property (set_w && cfg_r[0] && !cfg_r[1] |-> sw_out == in_w)
        else $error("window output wrong");
    win_inv_a: assert property (set_w && cfg_r[0] && cfg_r[1] |-> sw_out == !in_w)
        else $error("inverted window output wrong");
    status_mirror_a: assert property (reg_rd && reg_addr == OFS_STATUS |=>
        reg_rdata[2:0] == {$past(level), $past(sw_out)})
        else $error("status does not mirror output and level");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    unmapped_rd_a: assert property (reg_rd && reg_addr > OFS_KEY_VAL |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind tsw_top tsw_top_assertions #(.DLY_TICK_CYC(DLY_TICK_CYC)) chk_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sw_out(sw_out),
    .level(level)
);

/* File: tb/tsw_keypad_model.sv */
/* tsw_keypad_model: operator with three keys.
 * Assumes one-cycle press requests from the bench on clk_sys. */
`timescale 1ns/100ps
module tsw_keypad_model
    import tsw_pkg::*;
(
    // clock and bench request
    input wire logic clk_sys,
    input wire tsw_keys_t press,
    // keys towards the device
    output tsw_keys_t keys
);
    logic [2:0] cnt_r = 3'h0;

    initial keys = 3'h0;

    // a press is held four cycles, then released, so each gives one clean edge
    always @(posedge clk_sys)
    begin
        if (press != 3'h0)
        begin
            keys <= press;
            cnt_r <= 3'h3;
        end
        else if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
        else
            keys <= 3'h0;
    end
endmodule

/* File: tb/tsw_top_tb_top.sv */
/* tsw_top_tb_top: register-level tests of the switching output.
 * Assumes a short delay tick of 4 cycles. */
`timescale 1ns/100ps
module tsw_top_tb_top
    import tsw_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] meas_raw = 16'h0000;
    logic meas_vld = 1'b0;
    logic [15:0] sens_freq = 16'h0abc;
    logic cal_ok = 1'b0;
    logic [15:0] cal_k = 16'h0000;
    tsw_keys_t press = 3'h0;
    tsw_keys_t keys;
    logic sw_out;
    logic [1:0] level;
    logic [NUM_CHARS*NUM_SEGS-1:0] disp_seg;
    logic [31:0] rv;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // expected output per mode, step 0 in bit 0
    logic [4:0] exp_tab [4] = '{5'b01100, 5'b10011, 5'b11010, 5'b00101};
    logic [15:0] seq [5] = '{16'h0050, 16'h0180, 16'h0200, 16'h0180, 16'h0100};

    always #25 clk_sys = ~clk_sys;

    tsw_top #(.DLY_TICK_CYC(4)) DUT (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .meas_raw(meas_raw),
        .meas_vld(meas_vld),
        .sens_freq(sens_freq),
        .cal_ok(cal_ok),
        .cal_k(cal_k),
        .keys(keys),
        .sw_out(sw_out),
        .level(level),
        .disp_seg(disp_seg)
    );

    tsw_keypad_model keypad (.clk_sys(clk_sys), .press(press), .keys(keys));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rv = reg_rdata;
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task key(input tsw_keys_t k);
        @(posedge clk_sys);
        press <= k;
        @(posedge clk_sys);
        press <= 3'h0;
        settle(8);
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            results();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(1);
        chk(32'(disp_seg[14:0]), 32'(GLYPH[0]));
        rd(OFS_THR_HI);
        chk(rv, 32'h0000ffff);
        rd(OFS_K_EFF);
        chk(rv, 32'h00000100);
        rd(8'h2c);
        chk(rv, 32'h0);
        $display("test reset done");
        wr(OFS_THR_LO, 32'h100);
        wr(OFS_THR_HI, 32'h200);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_CTRL, {28'h0, 2'b10, m[0], m[1]});
            for (int i = 0; i < 5; i++)
            begin
                wr(OFS_SIM_VAL, {16'h0, seq[i]});
                settle(3);
                chk(32'(sw_out), 32'(exp_tab[m][i]));
            end
        end
        rd(OFS_PV);
        chk(rv, 32'h100);
        chk(32'(disp_seg[44:30]), 32'(GLYPH[1]));
        $display("test modes done");
        wr(OFS_DELAY, 32'h3);
        wr(OFS_CTRL, 32'h0c);
        wr(OFS_SIM_VAL, 32'h50);
        wr(OFS_SIM_VAL, 32'h200);
        settle(6);
        chk(32'(sw_out), 32'h0);
        wr(OFS_SIM_VAL, 32'h50);
        settle(30);
        chk(32'(sw_out), 32'h0);
        wr(OFS_SIM_VAL, 32'h200);
        settle(8);
        chk(32'(sw_out), 32'h0);
        settle(20);
        chk(32'(sw_out), 32'h1);
        $display("test delay done");
        wr(OFS_CTRL, 32'h0);
        @(posedge clk_sys);
        meas_raw <= 16'h1234;
        meas_vld <= 1'b1;
        settle(4);
        rd(OFS_PV);
        chk(rv, 32'h1234);
        wr(OFS_CTRL, 32'h90);
        @(posedge clk_sys);
        meas_raw <= 16'h2000;
        settle(4);
        rd(OFS_PV);
        chk(32'(rv >= 32'h1234 && rv < 32'h1400), 32'h1);
        $display("test filter done");
        wr(OFS_KFIT, 32'h200);
        wr(OFS_KSENS, 32'h180);
        rd(OFS_K_EFF);
        chk(rv, 32'h300);
        @(posedge clk_sys);
        cal_k <= 16'h0123;
        cal_ok <= 1'b1;
        @(posedge clk_sys);
        cal_ok <= 1'b0;
        rd(OFS_K_EFF);
        chk(rv, 32'h123);
        chk(32'(disp_seg[29:0]), {2'b00, GLYPH[2], GLYPH[3]});
        $display("test factor done");
        key(3'b100);
        key(3'b001);
        chk(32'(level), 32'h1);
        key(3'b100);
        key(3'b010);
        key(3'b100);
        key(3'b001);
        chk(32'(level), 32'h2);
        rd(OFS_KEY_VAL);
        chk(rv, 32'h11);
        chk(32'(disp_seg[14:0]), 32'(GLYPH[12]));
        key(3'b001);
        chk(32'(level), 32'h0);
        rd(OFS_STATUS);
        chk(rv, 32'h00000009);
        wr(OFS_CTRL, 32'h190);
        rd(OFS_K_EFF);
        chk(rv, 32'h300);
        $display("test keypad done");
        results();
    end
endmodule
